// ===== core/acr_control.sv
// Converter control and status registers with sequencer, AHB-Lite slave
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module acr_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Trigger and clock pins from outside
  input wire logic timer_out0,
  input wire logic timer_out1,
  input wire logic timer_out2,
  input wire logic internal_conv_oscillator,
  input wire logic aux_clock,
  input wire logic main_clock,
  input wire logic sub_main_clock,
  // Converter core side
  input wire logic [9:0] core_result,
  output logic core_sample,
  output logic core_convert,
  output logic [3:0] core_channel,
  output logic converter_power,
  output logic ref_generator_on,
  output logic ref_voltage_select,
  // Transfer controller and interrupt
  input wire logic transfer_controller_active,
  input wire logic transfer_block_done,
  output logic result_loaded,
  output logic conv_irq,
  input wire logic conv_irq_accept
);
  // ==========================================================
  // Register state
  logic [7:0] primary;
  logic [15:0] secondary;
  logic [9:0] result_raw;
  logic busy;

  wire multi_sample_conv = primary[acr_pkg::MSC_BIT];
  wire conv_irq_enable = primary[acr_pkg::IE_BIT];
  wire conv_irq_flag = primary[acr_pkg::IFG_BIT];
  wire conversion_enable = primary[acr_pkg::ENC_BIT];
  wire software_start = primary[acr_pkg::SC_BIT];
  wire [3:0] input_channel_sel = secondary[acr_pkg::CH_LSB +: 4];
  wire [1:0] trigger_source_sel = secondary[acr_pkg::TSRC_LSB +: 2];
  wire result_format = secondary[acr_pkg::FMT_BIT];
  wire trigger_invert = secondary[acr_pkg::INV_BIT];
  wire [2:0] clock_divider_sel = secondary[acr_pkg::DIV_LSB +: 3];
  wire [1:0] clock_source_sel = secondary[acr_pkg::CSRC_LSB +: 2];
  wire [1:0] sequence_mode_sel = secondary[acr_pkg::SEQ_LSB +: 2];

  assign converter_power = primary[acr_pkg::PWR_BIT];
  assign ref_generator_on = primary[acr_pkg::REF_GENERATOR_ON_BIT];
  assign ref_voltage_select = primary[acr_pkg::REFSEL_BIT] & ref_generator_on;

  // ==========================================================
  // Pin synchronisers: trigger inputs and the four clock sources
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  wire [6:0] pin_in = {sub_main_clock, main_clock, aux_clock, internal_conv_oscillator,
                       timer_out2, timer_out0, timer_out1};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end

  // ==========================================================
  // Converter clock: selected source edge, then divide by code plus one
  logic src_prev;
  logic [2:0] div_count;
  wire src_level = sync_b[3 + clock_source_sel];
  wire src_edge = src_level & ~src_prev;
  wire conv_tick = src_edge && (div_count == clock_divider_sel);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev <= 1'b0;
      div_count <= 3'h0;
    end else begin
      src_prev <= src_level;
      if (conv_tick || !converter_power)
        div_count <= 3'h0;
      else if (src_edge)
        div_count <= div_count + 3'h1;
    end
  end

  // ==========================================================
  // Sample-input signal: source select, optional invert, edge detect
  logic shi_prev;
  wire timer_pick = (trigger_source_sel == acr_pkg::TRIG_TIMER_OUT1) ? sync_b[0] :
                    (trigger_source_sel == acr_pkg::TRIG_TIMER_OUT0) ? sync_b[1] : sync_b[2];
  wire sw_source = (trigger_source_sel == acr_pkg::TRIG_SOFTWARE);
  wire sample_input_signal = (sw_source ? software_start : timer_pick) ^ trigger_invert;
  wire shi_rise = sample_input_signal & ~shi_prev;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      shi_prev <= 1'b0;
    else
      shi_prev <= sample_input_signal;
  end

  // ==========================================================
  // Sequencer
  typedef enum logic [1:0] {IDLE, WAIT_TRIG, SAMPLE, CONVERT} acr_state_type;
  acr_state_type state;
  logic [3:0] tick_count;
  logic [3:0] channel;
  logic armed;
  wire single_mode = (sequence_mode_sel == acr_pkg::SEQ_SINGLE);
  wire seq_mode = (sequence_mode_sel == acr_pkg::SEQ_CHANNELS) ||
                  (sequence_mode_sel == acr_pkg::SEQ_REPEAT_CHANNELS);
  wire repeat_mode = sequence_mode_sel[1];
  wire auto_next = multi_sample_conv && !single_mode && armed;
  wire go = conversion_enable && converter_power;
  wire conv_done = (state == CONVERT) && conv_tick && (tick_count == acr_pkg::CONV_TICKS);
  wire last_of_seq = !seq_mode || (channel == 4'h0);
  wire more = repeat_mode ? conversion_enable : !last_of_seq;
  assign result_loaded = conv_done;
  assign core_sample = (state == SAMPLE);
  assign core_convert = (state == CONVERT);
  assign core_channel = channel;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      tick_count <= 4'h0;
      channel <= 4'h0;
      armed <= 1'b0;
      result_raw <= 10'h000;
    end else begin
      unique case (state)
        IDLE: begin
          armed <= 1'b0;
          channel <= input_channel_sel;
          if (go && shi_rise) begin
            state <= SAMPLE;
            tick_count <= 4'h0;
          end
        end
        WAIT_TRIG: begin
          if (!go)
            state <= IDLE;
          else if (auto_next || shi_rise) begin
            state <= SAMPLE;
            tick_count <= 4'h0;
          end
        end
        SAMPLE: begin
          if (conv_tick) begin
            if (tick_count == acr_pkg::SAMPLE_TICKS) begin
              state <= CONVERT;
              tick_count <= 4'h0;
            end else
              tick_count <= tick_count + 4'h1;
          end
        end
        CONVERT: begin
          if (conv_tick)
            tick_count <= tick_count + 4'h1;
          if (conv_done) begin
            result_raw <= core_result;
            armed <= 1'b1;
            if (seq_mode)
              channel <= (channel == 4'h0) ? input_channel_sel : channel - 4'h1;
            state <= more ? WAIT_TRIG : IDLE;
          end
        end
      endcase
      if (!converter_power)
        state <= IDLE;
    end
  end
  // Busy covers the whole sequence, including waits between samples
  assign busy = (state != IDLE);

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  logic wr_pend;
  logic [7:0] wr_addr;
  wire take = hsel && hready && htrans[1];
  wire wr_primary = wr_pend && (wr_addr == acr_pkg::PRIMARY_OFFSET);
  wire wr_secondary = wr_pend && (wr_addr == acr_pkg::SECONDARY_OFFSET);
  // Locked fields keep old value while conversions are enabled
  wire [7:0] p_keep = conversion_enable ? acr_pkg::PRIMARY_LOCK_MASK : 8'h00;
  wire [15:0] s_keep = conversion_enable ? acr_pkg::SECONDARY_LOCK_MASK : 16'h0000;
  wire flag_set = transfer_controller_active ? transfer_block_done : conv_done;
  wire flag_clear_sw = wr_primary && !hwdata[acr_pkg::IFG_BIT];
  wire flag_clear = flag_clear_sw || (conv_irq_accept && conv_irq);
  wire [7:0] p_written = (primary & p_keep) | (hwdata[7:0] & ~p_keep);
  wire [15:0] s_written = (secondary & s_keep) | (hwdata[15:0] & ~s_keep);
  wire next_flag = flag_set | (conv_irq_flag & ~flag_clear);
  wire start_seen = (state != IDLE) || shi_rise;
  wire next_start = wr_primary ? hwdata[acr_pkg::SC_BIT] : (software_start & ~start_seen);
  wire [7:0] p_base = wr_primary ? p_written : primary;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      primary <= acr_pkg::PRIMARY_RESET;
      secondary <= acr_pkg::SECONDARY_RESET;
    end else begin
      wr_pend <= take && hwrite;
      wr_addr <= haddr[7:0];
      primary <= {p_base[7:3], next_flag, p_base[1], next_start};
      if (wr_secondary)
        secondary <= {s_written[15:1], 1'b0};
    end
  end

  // Result justification by format
  wire [15:0] result_view = result_format ? {result_raw, 6'h00} : {6'h00, result_raw};
  wire [7:0] rd_addr = haddr[7:0];
  wire [31:0] rd_value = (rd_addr == acr_pkg::PRIMARY_OFFSET) ? {24'h00_0000, primary} :
                         (rd_addr == acr_pkg::SECONDARY_OFFSET) ? {16'h0000, secondary[15:1], busy} :
                         (rd_addr == acr_pkg::RESULT_OFFSET) ? {16'h0000, result_view} :
                         (rd_addr == acr_pkg::STATUS_OFFSET) ? {28'h000_0000, channel} : 32'h0000_0000;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
      hrdata <= rd_value;
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign conv_irq = conv_irq_flag & conv_irq_enable;
endmodule // acr_control
`default_nettype wire

// ===== core/acr_pkg.sv
// Package: register map, field positions and constants of the converter control block
package acr_pkg;
  // Byte offsets (word aligned)
  localparam logic [7:0] PRIMARY_OFFSET = 8'h00;
  localparam logic [7:0] SECONDARY_OFFSET = 8'h04;
  localparam logic [7:0] RESULT_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  // Primary register fields
  localparam int MSC_BIT = 7;
  localparam int REFSEL_BIT = 6;
  localparam int REF_GENERATOR_ON_BIT = 5;
  localparam int PWR_BIT = 4;
  localparam int IE_BIT = 3;
  localparam int IFG_BIT = 2;
  localparam int ENC_BIT = 1;
  localparam int SC_BIT = 0;
  // Secondary register fields
  localparam int CH_LSB = 12;
  localparam int TSRC_LSB = 10;
  localparam int FMT_BIT = 9;
  localparam int INV_BIT = 8;
  localparam int DIV_LSB = 5;
  localparam int CSRC_LSB = 3;
  localparam int SEQ_LSB = 1;
  localparam int BUSY_BIT = 0;
  // Reset values
  localparam logic [7:0] PRIMARY_RESET = 8'h00;
  localparam logic [15:0] SECONDARY_RESET = 16'h0000;
  // Fields writable only while conversions are disabled
  localparam logic [7:0] PRIMARY_LOCK_MASK = 8'hC0;
  localparam logic [15:0] SECONDARY_LOCK_MASK = 16'hFFFE;
  // Converter core takes one more than this many converter clock ticks per conversion
  localparam logic [3:0] CONV_TICKS = 4'hB;
  localparam logic [3:0] SAMPLE_TICKS = 4'h4;
  typedef enum logic [1:0] {
    SEQ_SINGLE,
    SEQ_CHANNELS,
    SEQ_REPEAT_SINGLE,
    SEQ_REPEAT_CHANNELS
  } acr_seq_type;
  typedef enum logic [1:0] {
    TRIG_SOFTWARE,
    TRIG_TIMER_OUT1,
    TRIG_TIMER_OUT0,
    TRIG_TIMER_OUT2
  } acr_trig_type;
endpackage

// ===== dv/acr_control_props.sv
// Port-level assertions for the converter control block
`timescale 1ns/10ps
`default_nettype none
module acr_control_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Observed ports
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic core_sample,
  input wire logic core_convert,
  input wire logic [3:0] core_channel,
  input wire logic converter_power,
  input wire logic ref_generator_on,
  input wire logic ref_voltage_select,
  input wire logic result_loaded,
  input wire logic conv_irq,
  input wire logic conv_irq_accept,
  input wire logic transfer_block_done
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========
  // Sample and conversion last several divided ticks, never one cycle
  sequence s_sample_hold;
    core_sample [*8];
  endsequence
  sequence s_conv_hold;
    core_convert [*8];
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  AST_REF_GATED: assert property (ref_voltage_select |-> ref_generator_on)
    else $error("reference select without reference on");
  AST_SAMPLE_POWERED: assert property ($rose(core_sample) |-> converter_power)
    else $error("sample started while core off");
  AST_SAMPLE_HOLD: assert property ($rose(core_sample) |-> s_sample_hold)
    else $error("sample phase too short");
  AST_CONV_AFTER_SAMPLE: assert property ($rose(core_convert) |-> $past(core_sample))
    else $error("conversion without sample");
  AST_CONV_HOLD: assert property ($rose(core_convert) |-> s_conv_hold)
    else $error("conversion phase too short");
  AST_LOAD_AFTER_CONV: assert property (result_loaded |-> core_convert ##1 !core_convert)
    else $error("result load not at conversion end");
  AST_IRQ_ACCEPT: assert property (conv_irq && conv_irq_accept && !result_loaded && !transfer_block_done |=> !conv_irq)
    else $error("accepted request not cleared");
  AST_CHANNEL_HELD: assert property (core_convert && $past(core_convert) |-> $stable(core_channel))
    else $error("channel moved during conversion");
endmodule // acr_control_props
bind acr_control acr_control_props acr_control_props_i (.clk(clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
  .core_sample(core_sample), .core_convert(core_convert), .core_channel(core_channel),
  .converter_power(converter_power), .ref_generator_on(ref_generator_on), .ref_voltage_select(ref_voltage_select),
  .result_loaded(result_loaded), .conv_irq(conv_irq), .conv_irq_accept(conv_irq_accept),
  .transfer_block_done(transfer_block_done));
`default_nettype wire

// ===== dv/acr_core_model.sv
// Behavioural converter core and clock sources facing the control block
`timescale 1ns/10ps
`default_nettype none
module acr_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests from the control block
  input wire logic core_sample,
  input wire logic core_convert,
  input wire logic [3:0] core_channel,
  // Answers to the control block
  output logic [9:0] core_result,
  output logic [3:0] src_clocks
);
  logic [4:0] ticks;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ticks <= 5'h00;
    end else begin
      ticks <= ticks + 5'h01;
    end
  end
  // Fastest source is clk/4: the block samples sources as levels
  assign src_clocks = ticks[4:1];
  // Moving pattern outside conversion so stale data never passes for a result
  assign core_result = (core_convert && !core_sample) ? {core_channel, 6'h15} : {5'h1F, ~ticks};
endmodule // acr_core_model
`default_nettype wire

// ===== dv/acr_control_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`define ACR_EQ(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("BAD %0t %h %h", $time, g, e); end end
module acr_control_test;
  logic clk, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, tact = 1'b0, tdone = 1'b0, acc = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [1:0] htrans = 2'b00;
  logic [2:0] tpin = 3'b000;
  logic [3:0] srcs, chan;
  logic [9:0] res;
  logic hreadyout, hresp, smp, cnv, pwr, ron, rsel, loaded, irq;
  int failures = 0, checks_done = 0;
  acr_control acr_control_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_out0(tpin[0]), .timer_out1(tpin[1]), .timer_out2(tpin[2]), .internal_conv_oscillator(srcs[0]),
    .aux_clock(srcs[1]), .main_clock(srcs[2]), .sub_main_clock(srcs[3]), .core_result(res), .core_sample(smp),
    .core_convert(cnv), .core_channel(chan), .converter_power(pwr), .ref_generator_on(ron), .ref_voltage_select(rsel),
    .transfer_controller_active(tact), .transfer_block_done(tdone), .result_loaded(loaded), .conv_irq(irq),
    .conv_irq_accept(acc));
  acr_core_model acr_core_model_i (.clk(clk), .rst_n(rst_n), .core_sample(smp), .core_convert(cnv),
    .core_channel(chan), .core_result(res), .src_clocks(srcs));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for bus ready or a finished conversion
  task automatic wait_hi(input bit on_load, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((on_load ? loaded : hreadyout) !== 1'b1 && n < lim);
    if ((on_load ? loaded : hreadyout) !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_hi(1'b0, 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_hi(1'b0, 50);
    rd = hrdata;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `ACR_EQ(rd, e)
  endtask
  task automatic t_soft();
    chk_rd(8'h04, 32'h0000_0000);
    bus(1'b1, 8'h10, 32'h0000_FFFF);
    chk_rd(8'h10, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0013);
    @(posedge clk);
    `ACR_EQ(pwr, 1'b1)
    chk_rd(8'h00, 32'h0000_0012);
    chk_rd(8'h04, 32'h0000_0001);
    wait_hi(1'b1, 2000);
    chk_rd(8'h08, 32'h0000_0015);
    chk_rd(8'h00, 32'h0000_0016);
    `ACR_EQ(irq, 1'b0)
    chk_rd(8'h04, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0012);
    chk_rd(8'h00, 32'h0000_0012);
    $display("test software start done");
  endtask
  task automatic t_lock();
    bus(1'b1, 8'h04, 32'h0000_3200);
    chk_rd(8'h04, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_00F2);
    chk_rd(8'h00, 32'h0000_0032);
    `ACR_EQ({ron, rsel}, 2'b10)
    bus(1'b1, 8'h00, 32'h0000_0030);
    bus(1'b1, 8'h00, 32'h0000_0070);
    bus(1'b1, 8'h04, 32'h0000_3200);
    chk_rd(8'h04, 32'h0000_3200);
    `ACR_EQ({ron, rsel}, 2'b11)
    bus(1'b1, 8'h00, 32'h0000_007B);
    @(posedge clk);
    `ACR_EQ(chan, 4'h3)
    wait_hi(1'b1, 2000);
    chk_rd(8'h08, {16'h0000, 10'h0D5, 6'h00});
    `ACR_EQ(irq, 1'b1)
    acc <= 1'b1;
    @(posedge clk);
    acc <= 1'b0;
    repeat (2) @(posedge clk);
    `ACR_EQ(irq, 1'b0)
    $display("test lock and format done");
  endtask
  task automatic t_trig();
    int idx;
    logic inv;
    for (int code = 1; code < 4; code++) begin
      inv = (code == 3);
      idx = (code == 1) ? 1 : ((code == 2) ? 0 : 2);
      tpin <= {3{inv}};
      tact <= (code == 2);
      bus(1'b1, 8'h00, 32'h0000_0018);
      bus(1'b1, 8'h04, {16'h0000, 4'h0, code[1:0], 1'b0, inv, 8'h00});
      bus(1'b1, 8'h00, 32'h0000_001A);
      tpin[idx] <= !inv;
      repeat (4) @(posedge clk);
      tpin[idx] <= inv;
      wait_hi(1'b1, 2000);
      repeat (3) @(posedge clk);
      `ACR_EQ(irq, code != 2)
      tdone <= 1'b1;
      @(posedge clk);
      tdone <= 1'b0;
      repeat (2) @(posedge clk);
      `ACR_EQ(irq, 1'b1)
    end
    tact <= 1'b0;
    $display("test triggers done");
  endtask
  // Sequence of channels 2..0 with multi-sample, auxiliary source divided by two
  task automatic t_seq();
    bus(1'b1, 8'h00, 32'h0000_0018);
    bus(1'b1, 8'h04, 32'h0000_202A);
    chk_rd(8'h04, 32'h0000_202A);
    bus(1'b1, 8'h00, 32'h0000_009B);
    for (int i = 0; i < 3; i++) begin
      wait_hi(1'b1, 3000);
      `ACR_EQ(chan, 4'h2 - 4'(i))
      if (i == 0) begin
        chk_rd(8'h04, 32'h0000_202B);
      end
    end
    chk_rd(8'h08, 32'h0000_0015);
    `ACR_EQ(irq, 1'b1)
    chk_rd(8'h04, 32'h0000_202A);
    $display("test sequence done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_soft();
    t_lock();
    t_trig();
    t_seq();
    conclude();
  end
endmodule // acr_control_test
`default_nettype wire
